// [verilog/ctdv_defs.svh]
// constants for the constants-table debug view: offsets, reset values, widths
`ifndef CTDV_DEFS_SVH
`define CTDV_DEFS_SVH
`define CTDV_ADDR_W        8
`define CTDV_DATA_W        32
`define CTDV_NUM_ENTRIES   5
`define CTDV_OFF_ENTRY0    8'h80
`define CTDV_OFF_ENTRY1    8'h84
`define CTDV_OFF_ENTRY2    8'h88
`define CTDV_OFF_ENTRY3    8'h8c
`define CTDV_OFF_ENTRY4    8'h90
`define CTDV_OFF_STATUS    8'h94
`define CTDV_RST_ENTRY0    32'h0002_0000
`define CTDV_RST_ENTRY1    32'h4804_0000
`define CTDV_RST_ENTRY2    32'h4802_a000
`define CTDV_RST_ENTRY3    32'h0003_0000
`define CTDV_RST_ENTRY4    32'h0002_6000
`define CTDV_UNMAPPED_DATA 32'h0000_0000
`define CTDV_STAT_HALT_BIT 0
`endif

// [verilog/ctdv_pkg.sv]
// types for the constants-table debug view
package ctdv_pkg;
  typedef logic [7:0]  ctdv_addr_t;
  typedef logic [31:0] ctdv_word_t;
  // one register-port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    ctdv_addr_t addr;
    ctdv_word_t wdata;
  } ctdv_req_s;
  typedef enum logic [2:0] {
    CTDV_SEL_E0,
    CTDV_SEL_E1,
    CTDV_SEL_E2,
    CTDV_SEL_E3,
    CTDV_SEL_E4,
    CTDV_SEL_STATUS,
    CTDV_SEL_NONE
  } ctdv_sel_e;
endpackage : ctdv_pkg

// [verilog/ctdv_const_table_view.sv]
// read-only debug view of constants-table entries 0 to 4
// Notes on behaviour
// RULE1: a read of an entry register returns all 32 bits of the matching table slot.
// RULE2: entry registers are read-only and cannot alter a table slot.
// RULE3: the agent can inspect the table while the core is halted.
// RULE4: each read returns the slot's present value, sampled at the read, not an old copy.
// RULE5: slot 0 is viewed at offset 80h and reads 20000h after reset.
// RULE6: slot 1 is viewed at offset 84h and reads 48040000h after reset.
// RULE7: slot 2 is viewed at offset 88h and reads 4802A000h after reset.
// RULE8: slot 3 is viewed at offset 8Ch and reads 30000h after reset.
// RULE9: slot 4 is viewed at offset 90h and reads 26000h after reset.
// RULE10: a write to an entry register is accepted and ignored.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`include "ctdv_defs.svh"

module ctdv_const_table_view #(
  parameter int NUM_ENTRIES = `CTDV_NUM_ENTRIES
) (
  // clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 clk_en,
  // register port
  input  wire logic [`CTDV_ADDR_W-1:0]              reg_addr,
  input  wire logic [`CTDV_DATA_W-1:0]              reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [`CTDV_DATA_W-1:0]              reg_rdata,
  // live table slots from the core, same clock domain
  input  wire logic [NUM_ENTRIES*`CTDV_DATA_W-1:0]  table_slots,
  input  wire logic                                 core_halted,
  input  wire logic                                 table_valid
);

  ctdv_pkg::ctdv_req_s  req;
  ctdv_pkg::ctdv_sel_e  sel;
  ctdv_pkg::ctdv_word_t entry_live [NUM_ENTRIES];
  ctdv_pkg::ctdv_word_t rst_vals   [5];
  ctdv_pkg::ctdv_word_t rdata_d;
  logic                 [`CTDV_DATA_W-1:0] reg_rdata_q;
  logic                 wr_ignored_q;

  // gather the request into one carrier
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;
  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;

  // reset images of the table; shown until the core reports its table valid
  assign rst_vals[0] = `CTDV_RST_ENTRY0; // RULE5
  assign rst_vals[1] = `CTDV_RST_ENTRY1; // RULE6
  assign rst_vals[2] = `CTDV_RST_ENTRY2; // RULE7
  assign rst_vals[3] = `CTDV_RST_ENTRY3; // RULE8
  assign rst_vals[4] = `CTDV_RST_ENTRY4; // RULE9

  // per-slot live view; no latch so the value is the present one
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENTRIES; gi++) begin : g_slot
      assign entry_live[gi] = table_valid ? table_slots[gi*`CTDV_DATA_W +: `CTDV_DATA_W] // RULE1 RULE4
                                          : rst_vals[gi];
    end
  endgenerate

  // address decode
  always_comb begin
    case (req.addr)
      `CTDV_OFF_ENTRY0: sel = ctdv_pkg::CTDV_SEL_E0; // RULE5
      `CTDV_OFF_ENTRY1: sel = ctdv_pkg::CTDV_SEL_E1; // RULE6
      `CTDV_OFF_ENTRY2: sel = ctdv_pkg::CTDV_SEL_E2; // RULE7
      `CTDV_OFF_ENTRY3: sel = ctdv_pkg::CTDV_SEL_E3; // RULE8
      `CTDV_OFF_ENTRY4: sel = ctdv_pkg::CTDV_SEL_E4; // RULE9
      `CTDV_OFF_STATUS: sel = ctdv_pkg::CTDV_SEL_STATUS;
      default:          sel = ctdv_pkg::CTDV_SEL_NONE;
    endcase
  end

  // read mux; reads are allowed whether or not the core is halted
  always_comb begin
    case (sel)
      ctdv_pkg::CTDV_SEL_E0:     rdata_d = entry_live[0]; // RULE1 RULE3
      ctdv_pkg::CTDV_SEL_E1:     rdata_d = entry_live[1];
      ctdv_pkg::CTDV_SEL_E2:     rdata_d = entry_live[2];
      ctdv_pkg::CTDV_SEL_E3:     rdata_d = entry_live[3];
      ctdv_pkg::CTDV_SEL_E4:     rdata_d = entry_live[4];
      ctdv_pkg::CTDV_SEL_STATUS: rdata_d = {30'h0, table_valid, core_halted};
      default:                   rdata_d = `CTDV_UNMAPPED_DATA;
    endcase
  end

  // read data register: valid in the cycle after the strobe, held past it while clk_en is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h0;
    end else if (clk_en) begin
      reg_rdata_q <= req.rd ? rdata_d : 32'h0; // RULE4
    end
  end

  // writes have no storage target; this flag only marks a dropped write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ignored_q <= 1'b0;
    end else if (clk_en) begin
      wr_ignored_q <= req.wr; // RULE2 RULE10
    end
  end

  assign reg_rdata = reg_rdata_q;

  // a read of entry 0 returns the slot value seen at the strobe
  property p_entry0_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == `CTDV_OFF_ENTRY0) |=> reg_rdata == $past(entry_live[0]);
  endproperty
  a_entry0_read: assert property (p_entry0_read) else $error("entry 0 read mismatch"); // RULE1

  // entry 4 read tracks the live slot
  property p_entry4_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == `CTDV_OFF_ENTRY4 && table_valid)
        |=> reg_rdata == $past(table_slots[4*32 +: 32]);
  endproperty
  a_entry4_read: assert property (p_entry4_read) else $error("entry 4 not live"); // RULE4

  // reset image of entries before the table is valid
  sequence s_rd1_reset;
    clk_en && reg_rd && reg_addr == `CTDV_OFF_ENTRY1 && !table_valid;
  endsequence
  property p_entry1_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      s_rd1_reset |=> reg_rdata == `CTDV_RST_ENTRY1;
  endproperty
  a_entry1_reset: assert property (p_entry1_reset) else $error("entry 1 reset value wrong"); // RULE6

  property p_entry2_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == `CTDV_OFF_ENTRY2 && !table_valid) |=> reg_rdata == `CTDV_RST_ENTRY2;
  endproperty
  a_entry2_reset: assert property (p_entry2_reset) else $error("entry 2 reset value wrong"); // RULE7

  property p_entry3_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == `CTDV_OFF_ENTRY3 && !table_valid) |=> reg_rdata == `CTDV_RST_ENTRY3;
  endproperty
  a_entry3_reset: assert property (p_entry3_reset) else $error("entry 3 reset value wrong"); // RULE8

  property p_entry4_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == `CTDV_OFF_ENTRY4 && !table_valid) |=> reg_rdata == `CTDV_RST_ENTRY4;
  endproperty
  a_entry4_reset: assert property (p_entry4_reset) else $error("entry 4 reset value wrong"); // RULE9

  property p_entry0_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == `CTDV_OFF_ENTRY0 && !table_valid) |=> reg_rdata == `CTDV_RST_ENTRY0;
  endproperty
  a_entry0_reset: assert property (p_entry0_reset) else $error("entry 0 reset value wrong"); // RULE5

  // a write followed by a read still shows the slot, not the write data
  sequence s_wr_then_rd;
    (clk_en && reg_wr && reg_addr == `CTDV_OFF_ENTRY0 && !table_valid) ##1
      (clk_en && reg_rd && reg_addr == `CTDV_OFF_ENTRY0 && !table_valid);
  endsequence
  property p_write_ignored;
    @(posedge sys_clk) disable iff (!rst_n)
      s_wr_then_rd |=> reg_rdata == `CTDV_RST_ENTRY0;
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write altered entry"); // RULE10

  // halted core still readable
  property p_halted_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && core_halted && reg_rd && reg_addr == `CTDV_OFF_ENTRY2 && table_valid)
        |=> reg_rdata == $past(table_slots[2*32 +: 32]);
  endproperty
  a_halted_read: assert property (p_halted_read) else $error("halted read failed"); // RULE3

  // read data is zero after any enabled cycle without a read strobe, and the write marker follows reg_wr
  property p_no_rd_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && !reg_rd) |=> reg_rdata == 32'h0 && wr_ignored_q == $past(reg_wr);
  endproperty
  a_no_rd_zero: assert property (p_no_rd_zero) else $error("read data outside read slot"); // RULE2

  // clock enable low freezes the read data register
  property p_freeze;
    @(posedge sys_clk) disable iff (!rst_n)
      !clk_en |=> $stable(reg_rdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("read data moved while frozen"); // RULE4

  // status word shows halt and table-valid flags seen at the strobe
  property p_status_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == `CTDV_OFF_STATUS)
        |=> reg_rdata == {30'h0, $past(table_valid), $past(core_halted)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch"); // RULE3

  // unmapped offsets read as zero so no slot leaks through a wrong address
  property p_unmapped;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_rd && sel == ctdv_pkg::CTDV_SEL_NONE) |=> reg_rdata == `CTDV_UNMAPPED_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // RULE1

endmodule : ctdv_const_table_view

// [bench/ctdv_core_model.sv]
// core-side model: live constants-table slots and halt status
`timescale 1ns/100ps
module ctdv_core_model (
  // table content control from the bench
  input  wire logic [31:0]  seed,
  input  wire logic         live,
  // toward the view block
  output logic      [159:0] table_slots,
  output logic              core_halted,
  output logic              table_valid
);
  // every slot follows seed, so a stale copy in the view cannot pass
  always_comb begin
    for (int n = 0; n < 5; n++) begin
      table_slots[32*n +: 32] = seed + 32'h0001_0011 * n;
    end
  end
  // the core stays halted while the agent inspects the table
  assign core_halted = 1'b1;
  assign table_valid = live;
endmodule : ctdv_core_model

// [bench/ctdv_tb.sv]
// self-checking bench for the constants-table debug view
`timescale 1ns/100ps
module testbench;
  logic         sys_clk   = 1'b0;
  logic         rst_n     = 1'b0;
  logic         clk_en    = 1'b1;
  logic [7:0]   reg_addr  = 8'h00;
  logic [31:0]  reg_wdata = 32'h0000_0000;
  logic         reg_wr    = 1'b0;
  logic         reg_rd    = 1'b0;
  logic [31:0]  reg_rdata;
  logic [31:0]  seed      = 32'h1234_5678;
  logic         live      = 1'b0;
  logic [159:0] table_slots;
  logic         core_halted;
  logic         table_valid;
  int           err_total = 0;
  int           tests_run = 0;
  // one row per entry register: offset and image before the core fills the table
  logic [7:0]   row_addr [5] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90};
  logic [31:0]  row_exp  [5] = '{32'h0002_0000, 32'h4804_0000, 32'h4802_a000, 32'h0003_0000, 32'h0002_6000};
  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;
  ctdv_core_model core (.seed, .live, .table_slots, .core_halted, .table_valid);
  ctdv_const_table_view dut (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
                             .reg_rdata, .table_slots, .core_halted, .table_valid);
  // expected live slot value, worked out independently of the view
  function automatic logic [31:0] slotv(input int n);
    return seed + 32'h0001_0011 * n;
  endfunction : slotv
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk
  // read strobe for one cycle; data must stand in the next cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge sys_clk);
    #1 chk(reg_rdata, 32'h0000_0000);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // watchdog: the sequence needs under 80 cycles, well below the 2000-cycle limit
  initial begin
    #200000;
    err_total++;
    results();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk(reg_rdata, 32'h0000_0000);
    // reset images while the table is not yet filled
    for (int i = 0; i < 5; i++) begin
      rd(row_addr[i], row_exp[i]);
    end
    $display("reset images done");
    // live slots with the core halted; seed moves before each read
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      live <= 1'b1;
      seed <= seed ^ 32'hffff_0000;
      #1 rd(row_addr[i], slotv(i));
    end
    $display("live reads done");
    // writes are dropped: a read right after still shows the slot
    for (int i = 0; i < 5; i++) begin
      wr(row_addr[i], ~slotv(i));
      rd(row_addr[i], slotv(i));
    end
    rd(8'h7c, 32'h0000_0000);
    $display("write drop done");
    // status word: core halted and table valid
    rd(8'h94, 32'h0000_0003);
    $display("status done");
    // clock enable low holds the read data past its one-cycle slot
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= 8'h80;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    clk_en <= 1'b0;
    @(posedge sys_clk);
    clk_en <= 1'b1;
    #1 chk(reg_rdata, slotv(0));
    @(posedge sys_clk);
    #1 chk(reg_rdata, 32'h0000_0000);
    $display("freeze done");
    // reset in mid-run clears the read data, reads work again after it
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk(reg_rdata, 32'h0000_0000);
    rd(8'h80, slotv(0));
    $display("mid-run reset done");
    results();
  end
endmodule : testbench
